// ---- hdl/lap_pkg.sv ----
package lap_pkg;
  // sizes of the block
  localparam int NUM_PORTS = 11;
  localparam int PORT_W = 4;
  localparam int HASH_W = 8;
  localparam int WEIGHT_ENTRIES = 256;
  localparam int HASH_SLICES = 52;
  // key field widths
  localparam int MAC_W = 48;
  localparam int VID_W = 12;
  localparam int TOS_W = 8;
  localparam int L4P_W = 16;
  localparam int PROTO_W = 8;
  localparam int IP_W = 128;
  localparam int NEXT_HOP_W = 11;
  localparam int KEY_W = 2 * MAC_W + VID_W + TOS_W + 2 * L4P_W + PROTO_W + 2 * IP_W + PORT_W;
  // values after reset
  localparam logic [PORT_W-1:0] SP2LA_RESET = 4'h0;
  localparam logic [NUM_PORTS-1:0] MEMBERS_RESET = 11'h000;
  localparam logic [NUM_PORTS-1:0] WEIGHT_RESET = 11'h000;

  // aggregation control bits
  typedef struct packed {
    logic enable;
    logic hash_include_dest_mac;
    logic hash_include_source_mac;
    logic hash_include_vlan_id;
    logic hash_include_tos;
    logic hash_include_l4_fields;
    logic hash_include_ip_addresses;
    logic hash_include_next_hop;
  } lap_ctrl_t;

  // header fields of one packet
  typedef struct packed {
    logic [MAC_W-1:0] dest_mac;
    logic [MAC_W-1:0] source_mac;
    logic [VID_W-1:0] vlan_id;
    logic [TOS_W-1:0] tos;
    logic [L4P_W-1:0] l4_source;
    logic [L4P_W-1:0] l4_dest;
    logic [PROTO_W-1:0] ip_proto;
    logic [IP_W-1:0] source_ip;
    logic [IP_W-1:0] dest_ip;
    logic [NEXT_HOP_W-1:0] next_hop;
    logic routed;
    logic [PORT_W-1:0] source_port;
  } lap_fields_t;

  // table write command
  typedef struct packed {
    logic sp2la_we;
    logic members_we;
    logic weight_we;
    logic [HASH_W-1:0] addr;
    logic [NUM_PORTS-1:0] data;
  } lap_cfg_t;
endpackage

// ---- hdl/lap_port_select.sv ----
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Each source port is translated into an aggregate number by a per-port table.
// - A destination aggregate is looked up in a members table giving its physical port mask.
// - A hash over the enabled fields indexes a weight table that yields the port mask.
// - A weight entry with no port of the aggregate set makes the packet drop.
// - The key runs dest MAC, source MAC, VLAN, TOS, L4 ports, proto, IPs, source port.
// - Disabled key fields are zero and the source port is always included.
// - Routed packets put the next hop in the dest MAC field and zero the VLAN.
// - The L4 flag gates both L4 ports and proto, the IP flag gates both addresses.
// - The hash is the XOR of 52 byte slices of the key from the low end.
module lap_port_select #(
  parameter int NUM_PORTS = lap_pkg::NUM_PORTS
) (
  input wire logic clock, // core clock
  input wire logic rst, // sync reset
  input wire lap_pkg::lap_ctrl_t ctrl, // aggregation control
  input wire lap_pkg::lap_cfg_t cfg, // table write
  input wire logic [lap_pkg::PORT_W-1:0] sp_query, // source port in
  output logic [lap_pkg::PORT_W-1:0] source_port_aggregate_number, // aggregate out
  input wire logic pkt_valid, // packet fields valid
  input wire lap_pkg::lap_fields_t fields, // packet fields
  input wire logic [lap_pkg::PORT_W-1:0] dest_aggregate, // chosen aggregate
  output logic out_valid, // result valid
  output logic [NUM_PORTS-1:0] egress_mask, // selected port
  output logic out_drop, // no port selected
  output logic [lap_pkg::HASH_W-1:0] hash_index // hash used
);
  localparam int KW = lap_pkg::KEY_W;
  localparam int HW = lap_pkg::HASH_W;
  // bit positions of the key fields, counted from the low end
  localparam int SP_LO = 0;
  localparam int DIP_LO = SP_LO + lap_pkg::PORT_W;
  localparam int SIP_LO = DIP_LO + lap_pkg::IP_W;
  localparam int PROTO_LO = SIP_LO + lap_pkg::IP_W;
  localparam int L4D_LO = PROTO_LO + lap_pkg::PROTO_W;
  localparam int L4S_LO = L4D_LO + lap_pkg::L4P_W;
  localparam int TOS_LO = L4S_LO + lap_pkg::L4P_W;
  localparam int VID_LO = TOS_LO + lap_pkg::TOS_W;
  localparam int SA_LO = VID_LO + lap_pkg::VID_W;
  localparam int DA_LO = SA_LO + lap_pkg::MAC_W;
  // l4 group width and the zero pad above a next hop
  localparam int L4_GROUP_W = 2 * lap_pkg::L4P_W + lap_pkg::PROTO_W;
  localparam int NH_PAD_LO = DA_LO + lap_pkg::NEXT_HOP_W;
  localparam int NH_PAD_W = lap_pkg::MAC_W - lap_pkg::NEXT_HOP_W;

  // result flops behind the output ports
  logic out_valid_q;
  logic [NUM_PORTS-1:0] egress_mask_q;
  logic out_drop_q;
  logic [HW-1:0] hash_index_q;
  logic [lap_pkg::PORT_W-1:0] agg_q;

  logic [lap_pkg::PORT_W-1:0] source_to_aggregate_table [NUM_PORTS];
  logic [NUM_PORTS-1:0] aggregate_to_physical_table [NUM_PORTS];
  logic [NUM_PORTS-1:0] hash_weight_table [lap_pkg::WEIGHT_ENTRIES];

  // fold byte slices of the key
  function automatic logic [HW-1:0] fold_key(input logic [KW-1:0] key);
    logic [HW-1:0] h;
    h = '0;
    for (int j = 0; j < lap_pkg::HASH_SLICES; j++) begin
      h = h ^ key[j*HW +: HW];
    end
    return h;
  endfunction

  // a port or aggregate number that names a real table entry
  function automatic logic in_range(input logic [lap_pkg::PORT_W-1:0] n);
    return int'(n) < NUM_PORTS;
  endfunction

  // key field gating
  wire logic [lap_pkg::MAC_W-1:0] nh_field =
    ctrl.hash_include_next_hop ? {37'h0, fields.next_hop} : '0;
  wire logic [lap_pkg::MAC_W-1:0] da_field = fields.routed ? nh_field :
    (ctrl.hash_include_dest_mac ? fields.dest_mac : '0);
  wire logic [lap_pkg::MAC_W-1:0] sa_field =
    ctrl.hash_include_source_mac ? fields.source_mac : '0;
  wire logic [lap_pkg::VID_W-1:0] vid_field =
    (ctrl.hash_include_vlan_id && !fields.routed) ? fields.vlan_id : '0;
  wire logic [lap_pkg::TOS_W-1:0] tos_field =
    ctrl.hash_include_tos ? fields.tos : '0;
  wire logic l4_on = ctrl.hash_include_l4_fields;
  wire logic ip_on = ctrl.hash_include_ip_addresses;
  wire logic [KW-1:0] key = {da_field, sa_field, vid_field, tos_field,
    l4_on ? fields.l4_source : 16'h0000, l4_on ? fields.l4_dest : 16'h0000,
    l4_on ? fields.ip_proto : 8'h00,
    ip_on ? fields.source_ip : 128'h0, ip_on ? fields.dest_ip : 128'h0,
    fields.source_port};
  wire logic [HW-1:0] hash_d = fold_key(key);

  // table lookups
  wire logic [NUM_PORTS-1:0] weight_mask = hash_weight_table[hash_d];
  wire logic da_in_range = in_range(dest_aggregate);
  wire logic sp_in_range = in_range(sp_query);
  wire logic [NUM_PORTS-1:0] members = da_in_range ?
    aggregate_to_physical_table[dest_aggregate] : '0;
  wire logic [NUM_PORTS-1:0] select_mask = ctrl.enable ? (weight_mask & members) :
    (da_in_range ? NUM_PORTS'(1) << dest_aggregate : '0);
  wire logic [lap_pkg::PORT_W-1:0] agg_d = !ctrl.enable ? sp_query :
    (sp_in_range ? source_to_aggregate_table[sp_query] : sp_query);

  // per-port table storage
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    always_ff @(posedge clock) begin
      if (rst) begin
        source_to_aggregate_table[p] <= lap_pkg::SP2LA_RESET;
        aggregate_to_physical_table[p] <= lap_pkg::MEMBERS_RESET;
      end else if (cfg.addr == HW'(p)) begin
        if (cfg.sp2la_we) source_to_aggregate_table[p] <= cfg.data[lap_pkg::PORT_W-1:0];
        if (cfg.members_we) aggregate_to_physical_table[p] <= cfg.data;
      end
    end
  end

  // weight table storage
  for (genvar w = 0; w < lap_pkg::WEIGHT_ENTRIES; w++) begin : g_weight
    always_ff @(posedge clock) begin
      if (rst) begin
        hash_weight_table[w] <= lap_pkg::WEIGHT_RESET;
      end else if (cfg.weight_we && cfg.addr == HW'(w)) begin
        hash_weight_table[w] <= cfg.data;
      end
    end
  end

  // registered results
  always_ff @(posedge clock) begin
    if (rst) begin
      out_valid_q <= 1'b0;
      egress_mask_q <= '0;
      out_drop_q <= 1'b0;
      hash_index_q <= '0;
      agg_q <= '0;
    end else begin
      out_valid_q <= pkt_valid;
      egress_mask_q <= select_mask;
      out_drop_q <= pkt_valid && (select_mask == '0);
      hash_index_q <= hash_d;
      agg_q <= agg_d;
    end
  end

  // outputs straight from the result flops
  assign out_valid = out_valid_q;
  assign egress_mask = egress_mask_q;
  assign out_drop = out_drop_q;
  assign hash_index = hash_index_q;
  assign source_port_aggregate_number = agg_q;

  // a packet strobe and the cycle out of reset in which its result stands
  sequence s_pkt_result;
    pkt_valid ##1 !rst;
  endsequence

  // a weight write and the cycle in which the entry shows it
  sequence s_weight_written;
    cfg.weight_we ##1 !rst;
  endsequence

  // drop flag marks exactly the empty masks
  a_drop_on_empty: assert property (@(posedge clock) disable iff (rst)
    s_pkt_result |-> (out_drop == (egress_mask == '0)))
    else $error("drop flag disagrees with mask");
  // no drop without a packet behind it
  a_drop_needs_pkt: assert property (@(posedge clock) disable iff (rst)
    !pkt_valid |=> !out_drop)
    else $error("drop without a packet");
  // every packet gets a result strobe
  a_result_valid: assert property (@(posedge clock) disable iff (rst)
    s_pkt_result |-> out_valid)
    else $error("no result after packet");
  // selected ports stay inside the destination aggregate
  a_mask_in_members: assert property (@(posedge clock) disable iff (rst)
    ctrl.enable |=> ((egress_mask & ~$past(members)) == '0))
    else $error("egress mask outside aggregate");
  // selected ports come from the indexed weight entry
  a_weight_index: assert property (@(posedge clock) disable iff (rst)
    ctrl.enable |=> (egress_mask & ~$past(weight_mask)) == '0)
    else $error("mask not from weight entry");
  // a weight write lands in the addressed entry
  a_weight_write: assert property (@(posedge clock) disable iff (rst)
    s_weight_written |-> (hash_weight_table[$past(cfg.addr)] == $past(cfg.data)))
    else $error("weight entry not written");
  // hash register carries the fold of the cycle before
  a_hash_follows: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> hash_index == $past(hash_d))
    else $error("hash index stale");
  // with every field flag off the hash is the bare source port
  a_hash_sp_only: assert property (@(posedge clock) disable iff (rst)
    (ctrl[6:0] == 7'h00) |=> hash_index == HW'($past(fields.source_port)))
    else $error("hash not source port alone");
  // source port always sits at the low end of the key
  a_sp_always_in: assert property (@(posedge clock) disable iff (rst)
    key[SP_LO +: lap_pkg::PORT_W] == fields.source_port)
    else $error("source port missing from key");
  // source mac zero when left out
  a_sa_gated: assert property (@(posedge clock) disable iff (rst)
    !ctrl.hash_include_source_mac |-> key[SA_LO +: lap_pkg::MAC_W] == '0)
    else $error("source mac bits leak");
  // tos zero when left out
  a_tos_gated: assert property (@(posedge clock) disable iff (rst)
    !ctrl.hash_include_tos |-> key[TOS_LO +: lap_pkg::TOS_W] == '0)
    else $error("tos bits leak");
  // routed packets carry no vlan in the key
  a_routed_vlan_zero: assert property (@(posedge clock) disable iff (rst)
    fields.routed |-> key[VID_LO +: lap_pkg::VID_W] == '0)
    else $error("vlan not zero when routed");
  // routed dest mac field holds only a next hop
  a_routed_da_high: assert property (@(posedge clock) disable iff (rst)
    fields.routed |-> key[NH_PAD_LO +: NH_PAD_W] == '0)
    else $error("routed dest field above next hop");
  // routed dest mac field empty when next hop is left out
  a_next_hop_gated: assert property (@(posedge clock) disable iff (rst)
    (fields.routed && !ctrl.hash_include_next_hop) |-> key[DA_LO +: lap_pkg::MAC_W] == '0)
    else $error("next hop bits leak");
  // l4 ports and proto gated together
  a_l4_gated: assert property (@(posedge clock) disable iff (rst)
    !l4_on |-> key[PROTO_LO +: L4_GROUP_W] == '0)
    else $error("l4 bits leak");
  // both ip addresses gated together
  a_ip_gated: assert property (@(posedge clock) disable iff (rst)
    !ip_on |-> key[DIP_LO +: 2 * lap_pkg::IP_W] == '0)
    else $error("ip bits leak");
  // enabled translation reads the per-port table
  a_agg_map: assert property (@(posedge clock) disable iff (rst)
    (ctrl.enable && sp_in_range) |=>
    source_port_aggregate_number == $past(source_to_aggregate_table[sp_query]))
    else $error("aggregate map wrong");
endmodule // lap_port_select
`default_nettype wire

// ---- test/lap_ingress_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ingress pipeline side: offers one packet per call
module lap_ingress_model (
  input wire logic clock, // core clock
  output logic pkt_valid, // packet strobe
  output lap_pkg::lap_fields_t fields, // header fields
  output logic [3:0] dest_aggregate // chosen aggregate
);
  initial begin
    pkt_valid = 1'b0;
    fields = '0;
    dest_aggregate = 4'h0;
  end
  // one-cycle strobe, fields scrambled once it is over
  task automatic send(input lap_pkg::lap_fields_t f, input logic [3:0] agg);
    @(posedge clock) #1;
    pkt_valid = 1'b1;
    fields = f;
    dest_aggregate = agg;
    @(posedge clock) #1;
    pkt_valid = 1'b0;
    fields = ~f;
  endtask
endmodule // lap_ingress_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  lap_pkg::lap_ctrl_t ctrl = '0;
  lap_pkg::lap_cfg_t cfg = '0;
  logic [3:0] sp_query = 4'h0;
  logic [3:0] agg, dest_aggregate;
  logic pkt_valid, out_valid, out_drop;
  lap_pkg::lap_fields_t fields, f;
  logic [10:0] egress_mask;
  logic [7:0] hash_index, h;
  int failures = 0;
  int checks = 0;
  // core clock
  always #5 clock = ~clock;
  lap_port_select u_dut (.clock(clock), .rst(rst), .ctrl(ctrl), .cfg(cfg), .sp_query(sp_query),
    .source_port_aggregate_number(agg), .pkt_valid(pkt_valid), .fields(fields),
    .dest_aggregate(dest_aggregate), .out_valid(out_valid), .egress_mask(egress_mask),
    .out_drop(out_drop), .hash_index(hash_index));
  lap_ingress_model u_ing (.clock(clock), .pkt_valid(pkt_valid), .fields(fields),
    .dest_aggregate(dest_aggregate));
  // expected key and byte fold
  function automatic logic [7:0] fold(lap_pkg::lap_ctrl_t c, lap_pkg::lap_fields_t p);
    logic [415:0] k;
    logic [47:0] da;
    logic [7:0] r;
    da = c.hash_include_dest_mac ? p.dest_mac : 48'h0;
    if (p.routed) da = c.hash_include_next_hop ? {37'h0, p.next_hop} : 48'h0;
    k = {da, c.hash_include_source_mac ? p.source_mac : 48'h0,
      (c.hash_include_vlan_id && !p.routed) ? p.vlan_id : 12'h0,
      c.hash_include_tos ? p.tos : 8'h0,
      c.hash_include_l4_fields ? {p.l4_source, p.l4_dest, p.ip_proto} : 40'h0,
      c.hash_include_ip_addresses ? {p.source_ip, p.dest_ip} : 256'h0, p.source_port};
    r = 8'h0;
    for (int i = 0; i < 52; i++) r ^= k[i*8 +: 8];
    return r;
  endfunction
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // table write, held until the caller clears it
  task automatic wr(input logic [2:0] we, input logic [7:0] a, input logic [10:0] d);
    cfg = {we, a, d};
    @(posedge clock) #1;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // disabled: identity translation and one-hot mask
  task automatic t_identity();
    chk("out_valid", 11'h0, out_valid);
    sp_query = 4'h5;
    @(posedge clock) #1;
    chk("aggregate", 11'h5, agg);
    u_ing.send(f, 4'h4);
    chk("out_valid", 11'h1, out_valid);
    chk("egress_mask", 11'h010, egress_mask);
  endtask
  // program tables, then hash under several flag sets
  task automatic t_hash();
    logic [7:0] cs [4] = '{8'hFF, 8'h80, 8'hD5, 8'hAA};
    for (int p = 0; p < 11; p++) wr(3'h4, p[7:0], (p < 3) ? 11'h000 : 11'(p));
    for (int p = 3; p < 11; p++) wr(3'h2, p[7:0], 11'h001 << p);
    wr(3'h2, 8'h00, 11'h007);
    // ports 0 to 2 share aggregate 0, every other port keeps its own bit
    for (int i = 0; i < 256; i++) wr(3'h1, i[7:0], 11'h7F8 | (11'h001 << (i % 3)));
    cfg = '0;
    sp_query = 4'h1;
    ctrl = cs[0];
    @(posedge clock) #1;
    chk("aggregate", 11'h0, agg);
    sp_query = 4'h5;
    @(posedge clock) #1;
    chk("aggregate", 11'h5, agg);
    for (int m = 0; m < 4; m++) begin
      ctrl = cs[m];
      f.routed = m[1];
      h = fold(cs[m], f);
      u_ing.send(f, 4'h0);
      chk("hash_index", {3'h0, h}, hash_index);
      chk("egress_mask", 11'h001 << (h % 3), egress_mask);
      chk("out_drop", 11'h0, out_drop);
    end
    // a single-port aggregate resolves to its own port
    u_ing.send(f, 4'h6);
    chk("egress_mask", 11'h040, egress_mask);
  endtask
  // weight entry holding only port 6, none of aggregate 0, drops the packet
  task automatic t_drop();
    wr(3'h1, h, 11'h040);
    cfg = '0;
    u_ing.send(f, 4'h0);
    chk("out_drop", 11'h1, out_drop);
    chk("egress_mask", 11'h0, egress_mask);
    @(posedge clock) #1;
    chk("out_valid", 11'h0, out_valid);
    chk("out_drop", 11'h0, out_drop);
  endtask
  // reset in mid-run clears results and every table
  task automatic t_reset();
    rst = 1'b1;
    sp_query = 4'h5;
    repeat (2) @(posedge clock) #1;
    chk("out_valid", 11'h0, out_valid);
    chk("egress_mask", 11'h0, egress_mask);
    chk("hash_index", 11'h0, hash_index);
    chk("aggregate", 11'h0, agg);
    rst = 1'b0;
    @(posedge clock) #1;
    chk("aggregate", 11'h0, agg);
    chk("egress_mask", 11'h0, egress_mask);
  endtask
  initial begin
    f = '0;
    f.dest_mac = 48'h0102030405A6;
    f.source_mac = 48'hF1E2D3C4B5A6;
    f.vlan_id = 12'h7B1;
    f.tos = 8'h3C;
    f.l4_source = 16'h1234;
    f.l4_dest = 16'hBEEF;
    f.ip_proto = 8'h06;
    f.source_ip = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;
    f.dest_ip = 128'hFEDCBA98;
    f.next_hop = 11'h5A3;
    f.source_port = 4'h1;
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    t_identity();
    t_hash();
    t_drop();
    t_reset();
    results();
  end
endmodule // tb
`default_nettype wire
